//--- src/clock_trim_pkg.sv
package clock_trim_pkg;
  // ==========================================================
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_TRIGGER_GATE = 8'h4A; // outside trigger gate word
  localparam logic [7:0] ADDR_SAMPLE_CLOCK = 8'h4B; // sample clock gate and trim
  localparam logic [7:0] ADDR_TIMING_OSC = 8'h4D; // timing oscillator trim
  localparam logic [7:0] ADDR_CONVERTER = 8'h4E; // converter sequence setting
  localparam logic [7:0] ADDR_SYNC_SELECT = 8'h4F; // trigger source select word

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_TRIGGER_GATE = 16'h0000;
  localparam logic [15:0] RST_SAMPLE_CLOCK = 16'h2612;
  localparam logic [15:0] RST_TIMING_OSC = 16'h425E;
  localparam logic [15:0] RST_CONVERTER = 16'h0060;
  localparam logic [15:0] RST_SYNC_SELECT = 16'h2090;

  // ==========================================================
  // field positions
  localparam int BIT_OUTSIDE_GATE = 14; // in trigger gate word
  localparam int BIT_SAMPLE_GATE = 7; // in sample clock word
  localparam int SAMPLE_TRIM_MSB = 5;
  localparam int TIMING_TRIM_MSB = 7;
  localparam int BIT_SOURCE_SELECT = 2; // in sync select word
  localparam int BIT_PIN_INPUT_EN = 1; // in sync select word

  // ==========================================================
  // oscillator figures
  localparam longint CLK_HZ = 64'd20000000; // system clock rate
  localparam longint SAMPLE_NOM_HZ = 64'd32000; // sample oscillator centre
  localparam longint SAMPLE_STEP_HZ = 64'd600; // per trim code
  localparam longint SAMPLE_CENTER = 64'd34; // code 100010
  localparam longint TIMING_NOM_HZ = 64'd32000000; // timing oscillator default
  localparam longint TIMING_STEP_HZ = 64'd109000; // per trim code
  localparam longint TIMING_DEFAULT = 64'd94; // code 01011110
  localparam int TIMING_HZ_W = 26; // holds up to about 67 MHz
  localparam int PHASE_W = 32; // phase accumulator width
  localparam longint PHASE_SPAN = 64'd4294967296; // 2**PHASE_W
endpackage : clock_trim_pkg

//--- src/phase_osc.sv
`timescale 1ns/1ps
// ==========================================================
// phase accumulator oscillator: models a trimmable clock source
module phase_osc (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run, // low holds the output stopped
  input wire logic [clock_trim_pkg::PHASE_W-1:0] increment, // phase step per clk
  output logic oscOut, // square wave, msb of phase
  output logic wrapTick // one-cycle pulse per output period
);
  import clock_trim_pkg::*;

  logic [PHASE_W-1:0] phase; // accumulated phase
  logic [PHASE_W-1:0] next_phase;
  logic next_oscOut;
  logic next_wrapTick;
  logic [PHASE_W:0] sum; // phase plus step with carry

  // ==========================================================
  // next phase; a new increment takes effect on the next edge
  always_comb begin
    sum = {1'b0, phase} + {1'b0, increment};
    if (run) begin
      next_phase = sum[PHASE_W-1:0];
      next_oscOut = sum[PHASE_W-1];
      next_wrapTick = sum[PHASE_W];
    end else begin
      // stopped: phase parked at zero so restart is clean
      next_phase = '0;
      next_oscOut = 1'b0;
      next_wrapTick = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase <= '0;
      oscOut <= 1'b0;
      wrapTick <= 1'b0;
    end else begin
      phase <= next_phase;
      oscOut <= next_oscOut;
      wrapTick <= next_wrapTick;
    end
  end
endmodule : phase_osc

//--- src/sensor_clock_trim_regs.sv
`timescale 1ns/1ps
module sensor_clock_trim_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [clock_trim_pkg::ADDR_W-1:0] regAddr, // register index
  input wire logic regWrite, // one-cycle write strobe
  input wire logic [clock_trim_pkg::DATA_W-1:0] regWriteData,
  input wire logic regRead, // one-cycle read strobe
  output logic [clock_trim_pkg::DATA_W-1:0] regReadData, // read result
  output logic regReadValid, // one-cycle pulse with read result
  input wire logic intPin, // interrupt pin level as sample trigger
  output logic sampleClock, // gated sample clock
  output logic sampleTrigger, // one-cycle pulse starting a sample cycle
  output logic [5:0] sampleTrim, // live sample oscillator trim
  output logic [7:0] timingTrim, // live timing oscillator trim
  output logic [clock_trim_pkg::TIMING_HZ_W-1:0] timingOscHz, // timing oscillator rate
  output logic [clock_trim_pkg::DATA_W-1:0] converterWord, // converter sequence word
  output logic syncConfigMismatch // gate bit disagrees with select bit
);
  import clock_trim_pkg::*;

  // ==========================================================
  // helper functions
  // phase step for the sample oscillator; larger code is slower
  // the step is truncated, so each period runs a hair long
  // hz stays positive over all 64 codes, lowest at the top code
  function automatic logic [PHASE_W-1:0] sampleIncrement(input logic [5:0] code);
    longint hz;
    longint inc;
    hz = SAMPLE_NOM_HZ + (SAMPLE_CENTER - longint'(code)) * SAMPLE_STEP_HZ;
    inc = (hz * PHASE_SPAN) / CLK_HZ;
    return inc[PHASE_W-1:0];
  endfunction : sampleIncrement

  // timing oscillator frequency in Hz; larger code is faster
  // the full code range stays well inside TIMING_HZ_W bits
  function automatic logic [TIMING_HZ_W-1:0] timingHz(input logic [7:0] code);
    longint hz;
    hz = TIMING_NOM_HZ + (longint'(code) - TIMING_DEFAULT) * TIMING_STEP_HZ;
    return hz[TIMING_HZ_W-1:0];
  endfunction : timingHz

  // ==========================================================
  // register storage
  // reserved bits are kept exactly as software wrote them
  logic [DATA_W-1:0] triggerGateReg; // outside_trigger_gate word
  logic [DATA_W-1:0] sampleClockReg; // sample_clock_gate_and_trim
  logic [DATA_W-1:0] timingOscReg; // timing_oscillator_trim
  logic [DATA_W-1:0] converterReg; // converter_sequence_setting
  logic [DATA_W-1:0] syncSelectReg; // trigger_source_select word
  logic [DATA_W-1:0] next_triggerGateReg;
  logic [DATA_W-1:0] next_sampleClockReg;
  logic [DATA_W-1:0] next_timingOscReg;
  logic [DATA_W-1:0] next_converterReg;
  logic [DATA_W-1:0] next_syncSelectReg;
  logic [DATA_W-1:0] next_regReadData;
  logic next_regReadValid;

  // ==========================================================
  // register write and read decode
  // write and read each walk their own address chain
  // a read in the same cycle as a write returns the old word
  always_comb begin
    next_triggerGateReg = triggerGateReg;
    next_sampleClockReg = sampleClockReg;
    next_timingOscReg = timingOscReg;
    next_converterReg = converterReg;
    next_syncSelectReg = syncSelectReg;
    // each write touches only its own word
    if (regWrite) begin
      if (regAddr == ADDR_TRIGGER_GATE) begin
        next_triggerGateReg = regWriteData;
      end else if (regAddr == ADDR_SAMPLE_CLOCK) begin
        next_sampleClockReg = regWriteData;
      end else if (regAddr == ADDR_TIMING_OSC) begin
        next_timingOscReg = regWriteData;
      end else if (regAddr == ADDR_CONVERTER) begin
        next_converterReg = regWriteData;
      end else if (regAddr == ADDR_SYNC_SELECT) begin
        next_syncSelectReg = regWriteData;
      end
      // unmapped writes are dropped
    end
    // read returns stored value one cycle later
    next_regReadValid = regRead;
    next_regReadData = '0;
    if (regRead) begin
      if (regAddr == ADDR_TRIGGER_GATE) begin
        next_regReadData = triggerGateReg;
      end else if (regAddr == ADDR_SAMPLE_CLOCK) begin
        next_regReadData = sampleClockReg;
      end else if (regAddr == ADDR_TIMING_OSC) begin
        next_regReadData = timingOscReg;
      end else if (regAddr == ADDR_CONVERTER) begin
        next_regReadData = converterReg;
      end else if (regAddr == ADDR_SYNC_SELECT) begin
        next_regReadData = syncSelectReg;
      end
      // unmapped reads return zero
    end
  end

  // registers only
  // synchronous reset loads the power-up words
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      triggerGateReg <= RST_TRIGGER_GATE;
      sampleClockReg <= RST_SAMPLE_CLOCK;
      timingOscReg <= RST_TIMING_OSC;
      converterReg <= RST_CONVERTER;
      syncSelectReg <= RST_SYNC_SELECT;
      regReadData <= '0;
      regReadValid <= 1'b0;
    end else begin
      triggerGateReg <= next_triggerGateReg;
      sampleClockReg <= next_sampleClockReg;
      timingOscReg <= next_timingOscReg;
      converterReg <= next_converterReg;
      syncSelectReg <= next_syncSelectReg;
      regReadData <= next_regReadData;
      regReadValid <= next_regReadValid;
    end
  end

  // ==========================================================
  // field views
  // single control bits taken from the stored words
  logic sampleGateBit; // sample_clock_gate
  logic outsideGateBit; // outside_trigger_gate
  logic sourceSelectBit; // trigger_source_select
  logic pinInputEnable; // pin input enable
  assign sampleGateBit = sampleClockReg[BIT_SAMPLE_GATE];
  assign outsideGateBit = triggerGateReg[BIT_OUTSIDE_GATE];
  assign sourceSelectBit = syncSelectReg[BIT_SOURCE_SELECT];
  assign pinInputEnable = syncSelectReg[BIT_PIN_INPUT_EN];

  // ==========================================================
  // sample oscillator
  logic [PHASE_W-1:0] sampleInc; // live step from the trim field
  logic oscWave; // raw oscillator wave
  logic oscTick; // one pulse per oscillator period
  // trim changes reach the accumulator on the next edge, no restart
  assign sampleInc = sampleIncrement(sampleClockReg[SAMPLE_TRIM_MSB:0]);

  // oscillator runs only while gated on
  phase_osc phase_osc_inst (
    .clk(clk),
    .rst_b(rst_b),
    .run(sampleGateBit),
    .increment(sampleInc),
    .oscOut(oscWave),
    .wrapTick(oscTick)
  );

  // ==========================================================
  // trigger selection and output staging
  // intPin is taken as already synchronous to clk
  // pinLast resets low like the idle pin, so reset makes no false edge
  logic pinLast; // previous pin level for edge detect
  logic next_pinLast;
  logic next_sampleClock;
  logic next_sampleTrigger;
  logic [5:0] next_sampleTrim;
  logic [7:0] next_timingTrim;
  logic [TIMING_HZ_W-1:0] next_timingOscHz;
  logic [DATA_W-1:0] next_converterWord;
  logic next_syncConfigMismatch;

  // next values for every staged output
  always_comb begin
    next_pinLast = intPin;
    // clock forced low while gated off
    next_sampleClock = sampleGateBit & oscWave;
    if (sourceSelectBit) begin
      // pin rising edge starts a cycle when pin input is enabled
      next_sampleTrigger = pinInputEnable & intPin & ~pinLast;
    end else begin
      // internal clock ticks feed the rate divider downstream
      next_sampleTrigger = sampleGateBit & oscTick;
    end
    next_sampleTrim = sampleClockReg[SAMPLE_TRIM_MSB:0];
    next_timingTrim = timingOscReg[TIMING_TRIM_MSB:0];
    next_timingOscHz = timingHz(timingOscReg[TIMING_TRIM_MSB:0]);
    next_converterWord = converterReg;
    // software is expected to keep these two bits equal
    // status only: the block never forces the pairing itself
    next_syncConfigMismatch = outsideGateBit ^ sourceSelectBit;
  end

  // registers only
  // every output leaves straight from a flip-flop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinLast <= 1'b0;
      sampleClock <= 1'b0;
      sampleTrigger <= 1'b0;
      sampleTrim <= RST_SAMPLE_CLOCK[SAMPLE_TRIM_MSB:0];
      timingTrim <= RST_TIMING_OSC[TIMING_TRIM_MSB:0];
      timingOscHz <= TIMING_NOM_HZ[TIMING_HZ_W-1:0];
      converterWord <= RST_CONVERTER;
      syncConfigMismatch <= 1'b0;
    end else begin
      pinLast <= next_pinLast;
      sampleClock <= next_sampleClock;
      sampleTrigger <= next_sampleTrigger;
      sampleTrim <= next_sampleTrim;
      timingTrim <= next_timingTrim;
      timingOscHz <= next_timingOscHz;
      converterWord <= next_converterWord;
      syncConfigMismatch <= next_syncConfigMismatch;
    end
  end
endmodule : sensor_clock_trim_regs

//--- sim/sensor_clock_trim_regs_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checks on the trim register block
module sensor_clock_trim_regs_sva import clock_trim_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [15:0] regWriteData,
  input wire logic regRead,
  input wire logic [15:0] regReadData,
  input wire logic regReadValid,
  input wire logic sampleClock,
  input wire logic sampleTrigger,
  input wire logic [5:0] sampleTrim,
  input wire logic [7:0] timingTrim,
  input wire logic [25:0] timingOscHz,
  input wire logic [15:0] converterWord
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // write requests to the timing, sample clock and converter registers
  sequence s_timing_write;
    regWrite && regAddr == ADDR_TIMING_OSC;
  endsequence
  sequence s_sample_write;
    regWrite && regAddr == ADDR_SAMPLE_CLOCK;
  endsequence
  sequence s_converter_write;
    regWrite && regAddr == ADDR_CONVERTER;
  endsequence
  sequence s_gate_off;
    regWrite && regAddr == ADDR_SAMPLE_CLOCK && !regWriteData[BIT_SAMPLE_GATE];
  endsequence
  a_read_answers: assert property (regRead |=> regReadValid)
    else $error("read strobe not answered next cycle");
  a_no_stray_valid: assert property (!regRead |=> !regReadValid)
    else $error("read valid without a read");
  a_data_quiet: assert property (!regReadValid |-> regReadData == 16'h0000)
    else $error("read data not zero outside valid");
  a_trigger_pulse: assert property (sampleTrigger |=> !sampleTrigger)
    else $error("sample trigger longer than one cycle");
  a_timing_trim_live: assert property (s_timing_write |-> ##2
      timingTrim == $past(regWriteData[7:0], 2))
    else $error("timing trim not taken from write");
  a_sample_trim_live: assert property (s_sample_write |-> ##2
      sampleTrim == $past(regWriteData[5:0], 2))
    else $error("sample trim not taken from write");
  a_timing_rate: assert property ($stable(timingTrim) |->
      int'(timingOscHz) == 32000000 + (int'(timingTrim) - 94) * 109000)
    else $error("timing rate does not match trim");
  a_gate_stops: assert property (s_gate_off |-> ##3 !sampleClock [*8])
    else $error("sample clock runs with gate cleared");
  a_converter_live: assert property (s_converter_write |-> ##2
      converterWord == $past(regWriteData, 2))
    else $error("converter word not taken from write");
endmodule : sensor_clock_trim_regs_sva

bind sensor_clock_trim_regs sensor_clock_trim_regs_sva sensor_clock_trim_regs_sva_inst (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite),
  .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
  .regReadValid(regReadValid), .sampleClock(sampleClock), .sampleTrigger(sampleTrigger),
  .sampleTrim(sampleTrim), .timingTrim(timingTrim), .timingOscHz(timingOscHz),
  .converterWord(converterWord));

//--- sim/tb_sensor_clock_trim_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
// ==========================================================
// bench for the trim register block
module tb_sensor_clock_trim_regs;
  import clock_trim_pkg::*;
  logic clk = 0, rst_b = 0, regWrite = 0, regRead = 0, intPin = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWriteData = 16'h0000;
  logic [15:0] regReadData, converterWord;
  logic regReadValid, sampleClock, sampleTrigger, syncConfigMismatch;
  logic [5:0] sampleTrim;
  logic [7:0] timingTrim;
  logic [25:0] timingOscHz;
  int fails = 0, total_checks = 0;
  sensor_clock_trim_regs sensor_clock_trim_regs_inst (.clk(clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .regReadData(regReadData), .regReadValid(regReadValid), .intPin(intPin),
    .sampleClock(sampleClock), .sampleTrigger(sampleTrigger), .sampleTrim(sampleTrim),
    .timingTrim(timingTrim), .timingOscHz(timingOscHz), .converterWord(converterWord),
    .syncConfigMismatch(syncConfigMismatch));
  initial begin
    forever #25 clk = ~clk;
  end
  // one-cycle write, derived outputs settle two edges later
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk) begin regWrite = 1; regAddr = a; regWriteData = d; end
    @(negedge clk) regWrite = 0;
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk) begin regRead = 1; regAddr = a; end
    @(negedge clk) regRead = 0;
    `CHK("read valid", 1'b1, regReadValid)
    `CHK("read data", e, regReadData)
  endtask : rd
  // reset values and an unmapped read
  task automatic t_reset;
    `CHK("sample trim", 6'h12, sampleTrim)
    `CHK("timing trim", 8'h5E, timingTrim)
    `CHK("timing rate", 26'd32000000, timingOscHz)
    rd(ADDR_SAMPLE_CLOCK, RST_SAMPLE_CLOCK);
    rd(ADDR_TIMING_OSC, RST_TIMING_OSC);
    rd(ADDR_CONVERTER, RST_CONVERTER);
    rd(ADDR_SYNC_SELECT, RST_SYNC_SELECT);
    rd(ADDR_TRIGGER_GATE, RST_TRIGGER_GATE);
    rd(8'h4C, 16'h0000);
  endtask : t_reset
  // timing trim at both ends, other fields untouched
  task automatic t_timing;
    wr(ADDR_TIMING_OSC, 16'h00FF);
    `CHK("rate max", 26'd49549000, timingOscHz)
    `CHK("converter kept", 16'h0060, converterWord)
    wr(ADDR_TIMING_OSC, 16'h0000);
    `CHK("rate min", 26'd21754000, timingOscHz)
    rd(ADDR_TIMING_OSC, 16'h0000);
    wr(ADDR_CONVERTER, 16'h0040);
    `CHK("converter word", 16'h0040, converterWord)
    `CHK("trim kept", 8'h00, timingTrim)
  endtask : t_timing
  // trigger period against the inverse sample trim
  task automatic t_period(input int t);
    int n, lo, highs;
    lo = 20000000 / (32000 + (34 - t) * 600);
    wr(ADDR_SAMPLE_CLOCK, 16'h2680 | 16'(t));
    `CHK("sample trim", 6'(t), sampleTrim)
    for (n = 0; n < 3000 && sampleTrigger !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 3000 && sampleTrigger !== 1'b1; n++) @(negedge clk);
    `CHK("period in range", 1'b1, n >= lo && n <= lo + 1)
    // gate set: the clock spends about half of each period high
    highs = 0;
    repeat (lo) @(negedge clk) highs += (sampleClock === 1'b1);
    `CHK("clock runs", 1'b1, highs >= lo / 2 - 2 && highs <= lo / 2 + 2)
  endtask : t_period
  // gate cleared: clock and trigger silent
  task automatic t_gate_off;
    int hits = 0;
    wr(ADDR_SAMPLE_CLOCK, 16'h2612);
    repeat (2000) @(negedge clk) hits += (sampleClock !== 1'b0) + (sampleTrigger !== 1'b0);
    `CHK("silent clock", 0, hits)
  endtask : t_gate_off
  // pin-started sample cycle and pairing status
  task automatic t_pin;
    int hits = 0;
    wr(ADDR_SYNC_SELECT, 16'h2096);
    wr(ADDR_TRIGGER_GATE, 16'h4000);
    `CHK("paired", 1'b0, syncConfigMismatch)
    @(negedge clk) intPin = 1;
    repeat (4) @(negedge clk) hits += sampleTrigger;
    `CHK("pin pulses", 1, hits)
    intPin = 0;
    wr(ADDR_TRIGGER_GATE, 16'h0000);
    `CHK("unpaired", 1'b1, syncConfigMismatch)
    // pin input disabled: a pin edge starts nothing
    wr(ADDR_SYNC_SELECT, 16'h2094);
    hits = 0;
    @(negedge clk) intPin = 1;
    repeat (4) @(negedge clk) hits += (sampleTrigger !== 1'b0);
    `CHK("pin ignored", 0, hits)
    intPin = 0;
  endtask : t_pin
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #3000000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    t_reset();
    t_timing();
    t_period(0);
    t_period(34);
    t_period(63);
    t_gate_off();
    t_pin();
    finish_test();
  end
endmodule : tb_sensor_clock_trim_regs
